// *** rtl/gtsp_port.sv ***
// GCI system port: frame timing, slot data, pin multiplexing, APB registers
//
// Notes on behaviour
// - Frame marker at 8 kHz starts each frame; driven or received by config.
// - NT/TE non-auto config outputs strobe on second 64k channel.
// - Mode select low: three strapped select pins give the channel number.
// - Data out is open drain, bit updates on first rising bclk edge.
// - Data out floats outside own slot and when channel disabled.
// - Output bit clock 512 kHz auto, 1536 kHz NT/TE, line locked.
// - Bit clock synchronous with frame marker; one bit lasts two periods.
// - Data in sampled on second falling bclk edge, own slot only.
// - Non-auto configs: four general pins follow the I/O config register.
// - Auto configs: two test select pins choose the transmission test.
// - NT1 auto: control output high, low on 2B+D loopback message.
// - Repeater line side: control output high, low on analog loop request.
// - NT1/REPEATER_NETWORK_SIDE_CONFIG auto: second status input sent as line status bit 2.
// - Repeater auto configs: local error loop select high loops far-end error back locally.
// - Mode select low uses select pins; high uses two config pins.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module gtsp_port
  import gtsp_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System port pins
  input wire gtsp_pkg::gtsp_pins_type pins_in,
  output logic bit_clock_o,
  output logic bit_clock_oe,
  output logic frame_sync_a_o,
  output logic frame_sync_a_oe,
  output logic bus_data_out_o,
  output logic bus_data_out_oe,
  output logic second_channel_strobe,
  output logic [3:0] gp_pin_o,
  output logic [3:0] gp_pin_oe,
  // Line transceiver core side
  input wire gtsp_pkg::gtsp_line_type line_in,
  output logic line_status_bit_2,
  output logic febe_to_line,
  output logic febe_to_system,
  output logic [1:0] test_code
);

  import gtsp_pkg::*;

  typedef struct packed {
    logic [3:0] io_dir;
    logic [3:0] io_out;
    logic cms;
    logic chan_en;
    logic [31:0] tx_reg;
    logic [31:0] rx_reg;
    logic rx_valid;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [6:0] div_cnt;
    logic bclk_o;
    logic [7:0] fr_cnt;
    logic fsa_o;
    logic bclk_prev;
    logic fsa_prev;
    logic ph;
    logic [8:0] bit_cnt;
    logic [31:0] tx_sh;
    logic [31:0] rx_sh;
    logic bdo_oe;
    logic strobe;
    logic ext_ctrl;
    logic ls2;
    logic febe_line;
    logic febe_sys;
    logic [1:0] test;
    logic [3:0] gp_o;
    logic [3:0] gp_oe;
  } gtsp_state_type;

  gtsp_state_type state_ff;
  gtsp_state_type nxt_state;
  gtsp_pins_type sy;
  gtsp_cfg_type cfg;
  logic master;
  logic auto_mode;
  logic [2:0] chan;
  logic [6:0] half_cnt;
  logic [7:0] frame_len;
  logic bclk_now;
  logic fsa_now;
  logic hit;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  gtsp_sync #(
    .WIDTH(GTSP_PIN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(pins_in),
    .sync_out(sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  always_comb begin
    if (!sy.mode_sel) begin
      cfg = GTSP_CFG_LT_NT12;
      chan = sy.chan_sel;
    end else begin
      chan = GTSP_CHAN_DEF;
      case ({sy.conf2, sy.conf1})
        2'b00: cfg = GTSP_CFG_NT_TE;
        2'b01: cfg = GTSP_CFG_REPEATER_LINE_SIDE_CONFIG_AUTO;
        2'b10: cfg = GTSP_CFG_NT1_AUTO;
        2'b11: cfg = GTSP_CFG_REPEATER_NETWORK_SIDE_CONFIG_AUTO;
        default: cfg = GTSP_CFG_NT_TE;
      endcase
    end
  end

  // Repeater line side takes its timing from the far end
  assign master = (cfg == GTSP_CFG_LT_NT12) ? state_ff.cms :
                  (cfg != GTSP_CFG_REPEATER_LINE_SIDE_CONFIG_AUTO);
  assign auto_mode = (cfg != GTSP_CFG_LT_NT12) && (cfg != GTSP_CFG_NT_TE);
  assign half_cnt = auto_mode ? GTSP_HALF_AUTO : GTSP_HALF_NT;
  assign frame_len = auto_mode ? GTSP_FRAME_AUTO : GTSP_FRAME_NT;
  // Slave clocks pass the synchroniser; own clocks need not
  assign bclk_now = master ? state_ff.bclk_o : sy.bclk;
  assign fsa_now = master ? state_ff.fsa_o : sy.frame_sync_a;

  ////////////////////////////////////////////////////////////////////////////
  // APB read decode
  always_comb begin
    status_word = '0;
    status_word[GTSP_ST_GP_LSB +: 4] = sy.gp;
    status_word[GTSP_ST_CHAN_LSB +: 3] = chan;
    status_word[GTSP_ST_CFG_LSB +: 3] = cfg;
    status_word[GTSP_ST_TEST_LSB +: 2] = state_ff.test;
    status_word[GTSP_ST_EC_BIT] = state_ff.ext_ctrl;
    status_word[GTSP_ST_RXV_BIT] = state_ff.rx_valid;
    hit = 1'b1;
    rd_word = '0;
    case (paddr)
      GTSP_CTRL_OFS: begin
        rd_word[GTSP_CTRL_DIR_LSB +: 4] = state_ff.io_dir;
        rd_word[GTSP_CTRL_OUT_LSB +: 4] = state_ff.io_out;
        rd_word[GTSP_CTRL_CMS_BIT] = state_ff.cms;
        rd_word[GTSP_CTRL_EN_BIT] = state_ff.chan_en;
      end
      GTSP_TX_OFS: rd_word = state_ff.tx_reg;
      GTSP_RX_OFS: rd_word = state_ff.rx_reg;
      GTSP_STAT_OFS: rd_word = status_word;
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic bclk_rise;
    logic bclk_fall;
    logic ph_v;
    logic [8:0] cnt_v;
    logic in_slot;
    logic [4:0] idx;
    logic bit_v;
    logic [31:0] rx_v;
    logic rx_set;
    logic [3:0] gp_in;
    bclk_rise = 1'b0;
    bclk_fall = 1'b0;
    ph_v = 1'b0;
    cnt_v = '0;
    in_slot = 1'b0;
    idx = '0;
    bit_v = 1'b0;
    rx_v = '0;
    rx_set = 1'b0;
    gp_in = sy.gp;
    nxt_state = state_ff;

    // APB: one wait state so read data come from a register
    if (psel && penable && !state_ff.pready) begin
      nxt_state.pready = 1'b1;
      nxt_state.pslverr = !hit;
      nxt_state.prdata = rd_word;
    end else begin
      nxt_state.pready = 1'b0;
      nxt_state.pslverr = 1'b0;
    end
    if (psel && penable && state_ff.pready && pwrite) begin
      case (paddr)
        GTSP_CTRL_OFS: begin
          nxt_state.io_dir = pwdata[GTSP_CTRL_DIR_LSB +: 4];
          nxt_state.io_out = pwdata[GTSP_CTRL_OUT_LSB +: 4];
          nxt_state.cms = pwdata[GTSP_CTRL_CMS_BIT];
          nxt_state.chan_en = pwdata[GTSP_CTRL_EN_BIT];
        end
        GTSP_TX_OFS: nxt_state.tx_reg = pwdata;
        GTSP_STAT_OFS: begin
          if (pwdata[GTSP_ST_RXV_BIT]) begin
            nxt_state.rx_valid = 1'b0;
          end
        end
        default: nxt_state.tx_reg = state_ff.tx_reg;
      endcase
    end

    // Bit clock and frame marker generation when this end is master
    if (master) begin
      if (line_in.lock_pulse) begin
        nxt_state.div_cnt = '0;
      end else if (state_ff.div_cnt >= half_cnt - 7'h01) begin
        nxt_state.div_cnt = '0;
        nxt_state.bclk_o = !state_ff.bclk_o;
        if (!state_ff.bclk_o) begin
          // Frame marker changes on bit clock rising edges only
          if (state_ff.fr_cnt >= frame_len - 8'h01) begin
            nxt_state.fr_cnt = '0;
          end else begin
            nxt_state.fr_cnt = state_ff.fr_cnt + 8'h01;
          end
          nxt_state.fsa_o = (nxt_state.fr_cnt == '0);
        end
      end else begin
        nxt_state.div_cnt = state_ff.div_cnt + 7'h01;
      end
    end else begin
      nxt_state.div_cnt = '0;
      nxt_state.bclk_o = 1'b0;
      nxt_state.fsa_o = 1'b0;
      nxt_state.fr_cnt = '0;
    end

    // Edge detection of the port clock and frame marker
    nxt_state.bclk_prev = bclk_now;
    nxt_state.fsa_prev = fsa_now;
    bclk_rise = bclk_now && !state_ff.bclk_prev;
    bclk_fall = !bclk_now && state_ff.bclk_prev;
    ph_v = state_ff.ph;
    cnt_v = state_ff.bit_cnt;
    if (fsa_now && !state_ff.fsa_prev) begin
      // Next rising edge opens data bit 0 of the frame
      ph_v = 1'b1;
      cnt_v = GTSP_BIT_RST;
    end
    in_slot = (cnt_v[8:5] == {1'b0, chan});
    idx = cnt_v[4:0];

    if (bclk_rise) begin
      ph_v = !ph_v;
      if (!ph_v) begin
        cnt_v = cnt_v + 9'h001;
        in_slot = (cnt_v[8:5] == {1'b0, chan});
        idx = cnt_v[4:0];
        if (in_slot) begin
          // Word captured at slot start so a late write cannot tear it
          if (idx == GTSP_IDX_FIRST) begin
            bit_v = state_ff.tx_reg[GTSP_SLOT_BITS-1];
            nxt_state.tx_sh = {state_ff.tx_reg[30:0], 1'b0};
          end else begin
            bit_v = state_ff.tx_sh[GTSP_SLOT_BITS-1];
            nxt_state.tx_sh = {state_ff.tx_sh[30:0], 1'b0};
          end
          nxt_state.bdo_oe = state_ff.chan_en && !bit_v;
        end else begin
          nxt_state.bdo_oe = 1'b0;
        end
        nxt_state.strobe = (cfg == GTSP_CFG_NT_TE) &&
                           (cnt_v[8:3] == GTSP_SECOND_CHAN);
      end
    end
    if (!state_ff.chan_en) begin
      nxt_state.bdo_oe = 1'b0;
    end

    // Receive: second falling edge of the bit, own slot only
    if (bclk_fall && ph_v && in_slot) begin
      rx_v = {state_ff.rx_sh[30:0], sy.bdi};
      nxt_state.rx_sh = rx_v;
      if (idx == GTSP_IDX_LAST) begin
        nxt_state.rx_reg = rx_v;
        rx_set = state_ff.chan_en;
      end
    end
    // A new word beats a clear in the same cycle
    if (rx_set) begin
      nxt_state.rx_valid = 1'b1;
    end
    nxt_state.ph = ph_v;
    nxt_state.bit_cnt = cnt_v;

    // Auto-mode control and status pins
    case (cfg)
      GTSP_CFG_NT1_AUTO: nxt_state.ext_ctrl = !line_in.loop_2bd_req;
      GTSP_CFG_REPEATER_LINE_SIDE_CONFIG_AUTO: nxt_state.ext_ctrl = !line_in.analog_loop_request;
      default: nxt_state.ext_ctrl = 1'b1;
    endcase
    nxt_state.ls2 = ((cfg == GTSP_CFG_NT1_AUTO) ||
                     (cfg == GTSP_CFG_REPEATER_NETWORK_SIDE_CONFIG_AUTO)) && gp_in[1];
    nxt_state.test = auto_mode ? {sy.chan_sel[2], gp_in[3]} : 2'b00;
    // Local loop keeps the far-end error off the system side
    if (auto_mode && (cfg != GTSP_CFG_NT1_AUTO) && gp_in[2]) begin
      nxt_state.febe_line = line_in.febe_rx;
      nxt_state.febe_sys = 1'b0;
    end else begin
      nxt_state.febe_line = 1'b0;
      nxt_state.febe_sys = line_in.febe_rx;
    end

    // General pins
    if (!auto_mode) begin
      nxt_state.gp_oe = state_ff.io_dir;
      nxt_state.gp_o = state_ff.io_out;
    end else begin
      nxt_state.gp_oe = '0;
      nxt_state.gp_o = '0;
      nxt_state.gp_oe[2] = (cfg == GTSP_CFG_NT1_AUTO);
      nxt_state.gp_o[2] = nxt_state.ext_ctrl;
      nxt_state.gp_oe[1] = (cfg == GTSP_CFG_REPEATER_LINE_SIDE_CONFIG_AUTO);
      nxt_state.gp_o[1] = nxt_state.ext_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
      state_ff.io_dir <= GTSP_DIR_RST;
      state_ff.io_out <= GTSP_OUT_RST;
      state_ff.bit_cnt <= GTSP_BIT_RST;
      state_ff.ext_ctrl <= 1'b1;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops, except the clock and frame marker enables decoded from master and the constant data out level
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign bit_clock_o = state_ff.bclk_o;
  assign bit_clock_oe = master;
  assign frame_sync_a_o = state_ff.fsa_o;
  assign frame_sync_a_oe = master;
  // Open drain: pin only ever pulled low
  assign bus_data_out_o = 1'b0;
  assign bus_data_out_oe = state_ff.bdo_oe;
  assign second_channel_strobe = state_ff.strobe;
  assign gp_pin_o = state_ff.gp_o;
  assign gp_pin_oe = state_ff.gp_oe;
  assign line_status_bit_2 = state_ff.ls2;
  assign febe_to_line = state_ff.febe_line;
  assign febe_to_system = state_ff.febe_sys;
  assign test_code = state_ff.test;

endmodule // gtsp_port

// *** rtl/gtsp_pkg.sv ***
// Package: constants, configuration codes and carriers of the system port
package gtsp_pkg;

  // Register offsets (byte addresses)
  localparam logic [31:0] GTSP_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] GTSP_TX_OFS = 32'h0000_0004;
  localparam logic [31:0] GTSP_RX_OFS = 32'h0000_0008;
  localparam logic [31:0] GTSP_STAT_OFS = 32'h0000_000C;

  // CTRL fields
  localparam int GTSP_CTRL_DIR_LSB = 0;
  localparam int GTSP_CTRL_OUT_LSB = 4;
  localparam int GTSP_CTRL_CMS_BIT = 8;
  localparam int GTSP_CTRL_EN_BIT = 9;
  localparam logic [3:0] GTSP_DIR_RST = 4'h0;
  localparam logic [3:0] GTSP_OUT_RST = 4'h0;

  // STATUS fields
  localparam int GTSP_ST_GP_LSB = 0;
  localparam int GTSP_ST_CHAN_LSB = 4;
  localparam int GTSP_ST_CFG_LSB = 7;
  localparam int GTSP_ST_TEST_LSB = 10;
  localparam int GTSP_ST_EC_BIT = 12;
  localparam int GTSP_ST_RXV_BIT = 13;

  // Timing
  localparam int GTSP_CLK_HZ = 100_000_000;
  localparam int GTSP_FRAME_HZ = 8_000;
  localparam int GTSP_BCLK_NT_HZ = 1_536_000;
  localparam int GTSP_BCLK_AUTO_HZ = 512_000;
  localparam logic [6:0] GTSP_HALF_NT =
    7'(GTSP_CLK_HZ / (2 * GTSP_BCLK_NT_HZ));
  localparam logic [6:0] GTSP_HALF_AUTO =
    7'(GTSP_CLK_HZ / (2 * GTSP_BCLK_AUTO_HZ));
  localparam logic [7:0] GTSP_FRAME_NT =
    8'(GTSP_BCLK_NT_HZ / GTSP_FRAME_HZ);
  localparam logic [7:0] GTSP_FRAME_AUTO =
    8'(GTSP_BCLK_AUTO_HZ / GTSP_FRAME_HZ);

  // Slot layout: one channel is four bytes of data bits
  localparam int GTSP_SLOT_BITS = 32;
  localparam logic [5:0] GTSP_SECOND_CHAN = 6'h01;
  localparam logic [8:0] GTSP_BIT_RST = 9'h1FF;
  localparam logic [4:0] GTSP_IDX_FIRST = 5'h00;
  localparam logic [4:0] GTSP_IDX_LAST = 5'h1F;
  localparam logic [2:0] GTSP_CHAN_DEF = 3'h0;

  // Configuration codes
  typedef enum logic [2:0] {
    GTSP_CFG_LT_NT12 = 3'b000,
    GTSP_CFG_NT_TE = 3'b001,
    GTSP_CFG_NT1_AUTO = 3'b010,
    GTSP_CFG_REPEATER_LINE_SIDE_CONFIG_AUTO = 3'b011,
    GTSP_CFG_REPEATER_NETWORK_SIDE_CONFIG_AUTO = 3'b100
  } gtsp_cfg_type;

  // Pins from outside the clock domain, synchronised together
  typedef struct packed {
    logic bclk;
    logic frame_sync_a;
    logic bdi;
    logic [3:0] gp;
    logic [2:0] chan_sel;
    logic mode_sel;
    logic conf2;
    logic conf1;
  } gtsp_pins_type;

  // Messages from the line transceiver core, same clock
  typedef struct packed {
    logic loop_2bd_req;
    logic analog_loop_request;
    logic febe_rx;
    logic lock_pulse;
  } gtsp_line_type;

  localparam int GTSP_PIN_W = $bits(gtsp_pins_type);

endpackage

// *** rtl/gtsp_sync.sv ***
// Two-stage synchroniser for pins entering the pclk domain
`timescale 1ns/1ns
module gtsp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else if (ce) begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule // gtsp_sync

// *** tb/gtsp_port_monitor.sv ***
// Checker of APB answers and port pin timing
`timescale 1ns/1ns
module gtsp_port_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Port pins
  input wire logic bit_clock_o,
  input wire logic bit_clock_oe,
  input wire logic frame_sync_a_o,
  input wire logic bus_data_out_o,
  input wire logic second_channel_strobe
);
  logic [15:0] hc_ff, sw_ff, fw_ff;
  logic bo_ff, hv_ff, tg;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign tg = bit_clock_o != bo_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Counters, cheaper than long repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc_ff <= 16'h0000;
      sw_ff <= 16'h0000;
      fw_ff <= 16'h0000;
      bo_ff <= 1'b0;
      hv_ff <= 1'b0;
    end else begin
      bo_ff <= bit_clock_o;
      hc_ff <= tg ? 16'h0001 : hc_ff + 16'h0001;
      hv_ff <= tg ? bit_clock_oe : hv_ff;
      sw_ff <= second_channel_strobe ? sw_ff + 16'h0001 : 16'h0000;
      fw_ff <= frame_sync_a_o ? fw_ff + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence apb_access;
    psel && $rose(penable);
  endsequence
  // First toggle after a start is skipped: its phase is free
  sequence bclk_edge;
    bit_clock_oe && hv_ff && tg;
  endsequence
  apb_answer_a: assert property (
    apb_access |=> pready) else $error("ready late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("ready too long");
  slverr_ready_a: assert property (
    pslverr |-> pready) else $error("error without ready");
  open_drain_a: assert property (
    bus_data_out_o == 1'b0) else $error("data out driven high");
  strobe_cfg_a: assert property (
    second_channel_strobe |-> bit_clock_oe) else $error("strobe in slave");
  strobe_width_a: assert property (
    $fell(second_channel_strobe) |-> sw_ff inside {[16'h03F8:16'h0408]})
    else $error("strobe width");
  bclk_half_a: assert property (
    bclk_edge |-> hc_ff == 16'h0020 || hc_ff == 16'h0061)
    else $error("bit clock half period");
  fsa_width_a: assert property (
    bit_clock_oe && $fell(frame_sync_a_o) |->
    fw_ff inside {[16'h003C:16'h0044], [16'h00BE:16'h00C6]})
    else $error("frame marker width");
endmodule // gtsp_port_monitor

bind gtsp_port gtsp_port_monitor i_gtsp_port_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .bit_clock_o(bit_clock_o),
  .bit_clock_oe(bit_clock_oe), .frame_sync_a_o(frame_sync_a_o),
  .bus_data_out_o(bus_data_out_o),
  .second_channel_strobe(second_channel_strobe));

// *** tb/gtsp_gci_ctrl.sv ***
// Model of the GCI controller mastering clock and frame
`timescale 1ns/1ns
module gtsp_gci_ctrl #(
  parameter int FPER = 1000
) (
  // Slot and words
  input wire logic [2:0] chan,
  input wire logic [31:0] tx_word,
  output logic [31:0] rx_word,
  output int frames,
  output int stray,
  // Port lines
  input wire logic bdo_wire,
  output logic bclk,
  output logic frame_sync_a,
  output logic bdi
);
  int per;
  logic [31:0] sh;
  logic in_slot;
  assign in_slot = (per >> 6) == int'(chan);
  // Offset keeps bit clock edges off pclk edges
  initial begin
    bclk = 1'b0;
    frame_sync_a = 1'b0;
    bdi = 1'b1;
    per = FPER - 1;
    rx_word = 32'h0000_0000;
    sh = 32'h0000_0000;
    #1;
    forever begin
      // Free-running port clock with a fixed period
      bclk = 1'b1;
      #63;
      bclk = 1'b0;
      #62;
    end
  end
  // 1000 periods of 125 ns make an 8 kHz frame
  always @(negedge bclk) begin
    if (!bdo_wire && !in_slot)
      stray++;
    if (in_slot && per[0])
      sh = {sh[30:0], bdo_wire};
    if (in_slot && per[5:0] == 6'h3F)
      rx_word = sh;
    per = (per == FPER - 1) ? 0 : per + 1;
    frame_sync_a = per == 0;
    if (per == 0)
      frames++;
  end
  // Data in toggles outside the slot so stale levels never match
  always @(posedge bclk) begin
    if (!per[0])
      bdi = in_slot ? tx_word[31 - per[5:1]] : ~bdi;
  end
endmodule // gtsp_gci_ctrl

// *** tb/gtsp_port_tb.sv ***
// Testbench of the GCI system port against a controller model
`timescale 1ns/1ns
module gtsp_port_tb;
  import gtsp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, tx_word, m_rx;
  logic bit_clock_o, bit_clock_oe, frame_sync_a_o, frame_sync_a_oe;
  logic bus_data_out_o, bus_data_out_oe, second_channel_strobe;
  logic line_status_bit_2, febe_to_line, febe_sys, mode_sel, conf2, conf1;
  logic [3:0] gp_pin_o, gp_pin_oe, gp_drv, gp_wire;
  logic [2:0] chan_sel;
  logic [1:0] test_code;
  logic m_bclk, m_fsa, m_bdi, bdo_wire;
  gtsp_pins_type pins_in;
  gtsp_line_type line_in;
  int failures, n_tests, cyc, m_frames, m_stray;
  // Data out line has a pull-up
  assign bdo_wire = bus_data_out_oe ? bus_data_out_o : 1'b1;
  assign gp_wire = (gp_pin_oe & gp_pin_o) | (~gp_pin_oe & gp_drv);
  assign pins_in = {bit_clock_oe ? bit_clock_o : m_bclk,
    frame_sync_a_oe ? frame_sync_a_o : m_fsa, m_bdi, gp_wire, chan_sel,
    mode_sel, conf2, conf1};
  gtsp_port i_gtsp_port (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .bit_clock_o(bit_clock_o),
    .bit_clock_oe(bit_clock_oe), .frame_sync_a_o(frame_sync_a_o),
    .frame_sync_a_oe(frame_sync_a_oe), .bus_data_out_o(bus_data_out_o),
    .bus_data_out_oe(bus_data_out_oe), .gp_pin_o(gp_pin_o),
    .second_channel_strobe(second_channel_strobe), .gp_pin_oe(gp_pin_oe),
    .line_in(line_in), .line_status_bit_2(line_status_bit_2),
    .febe_to_line(febe_to_line), .febe_to_system(febe_sys),
    .test_code(test_code));
  gtsp_gci_ctrl i_gtsp_gci_ctrl (.chan(chan_sel), .tx_word(tx_word),
    .rx_word(m_rx), .frames(m_frames), .stray(m_stray),
    .bdo_wire(bdo_wire), .bclk(m_bclk), .frame_sync_a(m_fsa), .bdi(m_bdi));
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
      chk(32'h0, 32'h1, "no ready");
    @(posedge pclk);
  endtask
  task automatic restart(input logic ms, c2, c1);
    presetn <= 1'b0;
    mode_sel <= ms;
    conf2 <= c2;
    conf1 <= c1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic poll_valid();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[13] !== 1'b1 && n < 600) begin
      repeat (50) @(posedge pclk);
      apb(1'b0, GTSP_STAT_OFS, 32'h0);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, GTSP_CTRL_OFS, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    apb(1'b1, GTSP_CTRL_OFS, 32'h0000_005F);
    // Pins follow the register one cycle after the write lands
    @(posedge pclk);
    chk(32'({gp_pin_oe, gp_pin_o}), 32'hF5, "gp out");
    apb(1'b1, GTSP_CTRL_OFS, 32'h0);
    gp_drv <= 4'hA;
    repeat (4) @(posedge pclk);
    apb(1'b0, GTSP_STAT_OFS, 32'h0);
    chk(32'(rd[3:0]), 32'hA, "gp in");
  endtask
  task automatic t_slot();
    apb(1'b1, GTSP_TX_OFS, 32'h96F0_3C5A);
    apb(1'b1, GTSP_CTRL_OFS, 32'h0000_0200);
    repeat (2) begin
      apb(1'b1, GTSP_STAT_OFS, 32'h0000_2000);
      poll_valid();
    end
    apb(1'b0, GTSP_RX_OFS, 32'h0);
    chk(rd, tx_word, "rx word");
    chk(m_rx, 32'h96F0_3C5A, "tx word");
    chk(32'(m_stray), 32'h0, "drive off slot");
    apb(1'b0, GTSP_STAT_OFS, 32'h0);
    chk(32'(rd[6:4]), 32'h5, "channel");
  endtask
  task automatic t_off();
    int n, k;
    apb(1'b1, GTSP_CTRL_OFS, 32'h0);
    apb(1'b1, GTSP_STAT_OFS, 32'h0000_2000);
    n = m_frames;
    k = 0;
    while (m_frames < n + 2 && k < 30000) begin
      @(posedge pclk);
      k++;
    end
    chk(m_rx, 32'hFFFF_FFFF, "slot driven");
    apb(1'b0, GTSP_STAT_OFS, 32'h0);
    chk(32'(rd[13]), 32'h0, "rx flag");
  endtask
  task automatic t_ntte();
    int n;
    restart(1'b1, 1'b0, 1'b0);
    n = 0;
    while (second_channel_strobe !== 1'b1 && n < 14000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(second_channel_strobe), 32'h1, "strobe");
    chk(32'({bit_clock_oe, frame_sync_a_oe}), 32'h3, "oe");
    apb(1'b0, GTSP_STAT_OFS, 32'h0);
    chk(32'(rd[9:7]), 32'(GTSP_CFG_NT_TE), "cfg");
    repeat (1100) @(posedge pclk);
  endtask
  task automatic t_auto();
    for (int v = 0; v < 2; v++) begin
      gp_drv <= {v[0], 1'b0, v[0], 1'b0};
      chan_sel <= {v[0], 2'b01};
      line_in <= {v[0], 3'b000};
      restart(1'b1, 1'b1, 1'b0);
      chk(32'(test_code), v ? 32'h3 : 32'h0, "test");
      chk(32'(line_status_bit_2), 32'(v), "status");
      chk(32'(gp_wire[2]), 32'(1 - v), "nt1 ctrl");
      repeat (400) @(posedge pclk);
      gp_drv <= 4'h4;
      line_in <= {1'b0, v[0], 2'b10};
      restart(1'b1, 1'b0, 1'b1);
      chk(32'(gp_wire[1]), 32'(1 - v), "repeater_line_side_config ctrl");
      chk(32'(febe_to_line), 32'h1, "febe loop");
      chk(32'(febe_sys), 32'h0, "febe kept local");
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      print_verdict();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, mode_sel, conf2, conf1} = 6'h00;
    {paddr, pwdata} = 64'h0;
    gp_drv = 4'h0;
    chan_sel = 3'h5;
    line_in = 4'h0;
    tx_word = 32'hC3A5_0F96;
    restart(1'b0, 1'b0, 1'b0);
    t_regs();
    t_slot();
    t_off();
    t_ntte();
    t_auto();
    print_verdict();
  end
endmodule // gtsp_port_tb
